// ### hw/dsl_pkg.sv
// Package: constants and types for the stream discontinuity and load-lock block
package dsl_pkg;
	localparam int NUM_CH = 8;
	localparam int CH_W = 3;
	localparam int DST_ALIGN_W = 3;	// Lane bits of a 64-bit destination bus
	localparam int SRC_ALIGN_W = 2;	// Lane bits of a 32-bit source bus
	localparam int MAP_SPAN = 4096;	// Register map region in bytes
	localparam logic [CH_W-1:0] OWNER_RST = 3'h0;
	localparam logic LOCK_HELD_RST = 1'b0;

	// Instruction classes as seen by the lock arbiter
	typedef enum logic [3:0] {
		INS_NONE,
		INS_LOAD,
		INS_PLOAD,
		INS_STORE,
		INS_PSTORE,
		INS_ZSTORE,
		INS_RBAR,
		INS_WBAR,
		INS_WFP,
		INS_WFE,
		INS_END,
		INS_KILL,
		INS_ABORT,
		INS_OTHER
	} dsl_instr_t;

	// Register targeted by a move
	typedef enum logic [1:0] {
		MV_SRC,
		MV_DST,
		MV_CTL
	} dsl_mvtgt_t;

	// Control fields that matter for stream continuity
	typedef struct packed {
		logic [2:0] swapSize;
		logic dstInc;
		logic [2:0] dstBeat;
		logic srcInc;
		logic [2:0] srcBeat;
	} dsl_ctl_t;

	typedef enum {
		RS_RUN,
		RS_DRAIN_RD,
		RS_DRAIN_ALL,
		RS_FLUSH
	} dsl_rs_state_t;

	typedef struct packed {
		logic held;
		logic [CH_W-1:0] owner;
	} dsl_lock_t;
endpackage

// ### hw/dsl_lock_if.sv
// Interface: instruction issue from the channel sequencer toward the load-lock arbiter
`timescale 1ns/100ps
interface dsl_lock_if;
	import dsl_pkg::*;
	dsl_instr_t instr;
	logic [CH_W-1:0] ch;
	logic issue;
	logic grant;
	logic held;
	logic [CH_W-1:0] owner;
	modport arb(input instr, input ch, input issue, output grant, output held, output owner);
	modport req(output instr, output ch, output issue, input grant, input held, input owner);
endinterface

// ### hw/dsl_load_lock.sv
// Load-lock arbiter for the shared data FIFO
`timescale 1ns/100ps
module dsl_load_lock (
	input wire logic clk,
	input wire logic rst_n,
	dsl_lock_if.arb lk
);
	import dsl_pkg::*;

	dsl_lock_t s;
	dsl_lock_t next_s;
	logic isLoad;
	logic isRelease;

	////////////////////////////////////////////////////////////////
	// Classify instruction
	always_comb begin
		isLoad = lk.issue && (lk.instr == INS_LOAD || lk.instr == INS_PLOAD);
		isRelease = 1'b0;
		if (lk.issue) begin
			case (lk.instr)
				INS_STORE, INS_PSTORE, INS_ZSTORE: isRelease = 1'b1;
				INS_RBAR, INS_WBAR: isRelease = 1'b1;
				INS_WFP, INS_WFE: isRelease = 1'b1;
				INS_END, INS_KILL, INS_ABORT: isRelease = 1'b1;
				default: isRelease = 1'b0;
			endcase
		end
	end

	// Grant is combinational so a stalled load retries every cycle
	assign lk.grant = isLoad && (!s.held || s.owner == lk.ch);
	assign lk.held = s.held;
	assign lk.owner = s.owner;

	////////////////////////////////////////////////////////////////
	// Token: free or held by exactly one channel
	always_comb begin
		next_s = s;
		if (lk.grant) begin
			next_s.held = 1'b1;
			next_s.owner = lk.ch;
		end else if (isRelease && s.held && s.owner == lk.ch) begin
			next_s.held = 1'b0;
			next_s.owner = OWNER_RST;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '{held: LOCK_HELD_RST, owner: OWNER_RST};
		end else begin
			s <= next_s;
		end
	end
endmodule

// ### hw/dsl_stream_ctrl.sv
// Top: stream discontinuity resync per channel plus load-lock arbitration
`timescale 1ns/100ps
// Operation
// - Destination lane, swap size, increment or fixed-address beat change means destination discontinuity
// - Dest break: halt, drain all, flush, resume
// - Source lane, increment or beat change means source discontinuity
// - Source break: halt, drain reads, keep FIFO
// - One load-lock token, free or single owner
// - Non-owner stalls at load until owning
// - Load claims lock when token free
// - Any store by the owner releases the lock
// - Read or write barrier releases lock
// - Peripheral or event wait releases lock
// - Finish or any abort releases lock
// - Register map spans a 4KB region (MAP_SPAN), decoded outside this block
// - All state clears to zero at reset
module dsl_stream_ctrl #(
	parameter int NCH = dsl_pkg::NUM_CH,
	parameter int DST_AW = dsl_pkg::DST_ALIGN_W,
	parameter int SRC_AW = dsl_pkg::SRC_ALIGN_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic issue,
	input wire dsl_pkg::dsl_instr_t instr,
	input wire logic [dsl_pkg::CH_W-1:0] issueCh,
	input wire logic [31:0] moveData,
	input wire dsl_pkg::dsl_mvtgt_t moveTarget,
	input wire logic isMove,
	input wire logic [NCH-1:0] rdPending,
	input wire logic [NCH-1:0] wrPending,
	input wire logic [NCH-1:0] flushDone,
	output logic issueAccept,
	output logic [NCH-1:0] chHalted,
	output logic [NCH-1:0] fifoFlushReq,
	output logic [NCH-1:0] dstBreak,
	output logic [NCH-1:0] srcBreak,
	output logic lockHeld,
	output logic [dsl_pkg::CH_W-1:0] lockOwner
);
	import dsl_pkg::*;

	// Per-channel architectural copies of continuity-relevant state
	typedef struct packed {
		dsl_rs_state_t st;
		dsl_ctl_t ctl;
		logic [DST_AW-1:0] dAlign;
		logic [SRC_AW-1:0] sAlign;
		logic dstB;
		logic srcB;
	} dsl_chan_t;

	typedef struct packed {
		dsl_chan_t [NCH-1:0] ch;
	} dsl_state_t;

	dsl_state_t s;
	dsl_state_t next_s;
	dsl_lock_if lk();
	logic running;
	dsl_ctl_t newCtl;
	// Break decision for the issuing channel and the triggers behind it.
	// Only one channel issues per cycle, so one set of flags serves them all
	// and the per-channel loop below only has to act on the result.
	logic dHit;
	logic sHit;
	logic dLaneChg;
	logic sLaneChg;
	logic swapChg;
	logic dIncChg;
	logic dBeatChg;
	logic sIncChg;
	logic sBeatChg;

	dsl_load_lock u_lock (
		.clk(clk),
		.rst_n(rst_n),
		.lk(lk)
	);

	////////////////////////////////////////////////////////////////
	// Issue path: halted channels can issue only kill or abort, loads need the token
	always_comb begin
		running = (s.ch[issueCh].st == RS_RUN);
		newCtl = dsl_ctl_t'(moveData[$bits(dsl_ctl_t)-1:0]);	// Bits above the control fields are ignored
	end

	assign lk.instr = instr;
	assign lk.ch = issueCh;
	// Aborts pass even while halted so the token never leaks
	assign lk.issue = issue && (running || instr == INS_KILL || instr == INS_ABORT);
	assign issueAccept = issue && (running || instr == INS_KILL || instr == INS_ABORT)
		&& ((instr != INS_LOAD && instr != INS_PLOAD) || lk.grant);
	assign lockHeld = lk.held;
	assign lockOwner = lk.owner;

	////////////////////////////////////////////////////////////////
	// Register map: controls arrive here as plain ports, so this block
	// holds no address decoder. The wrapper that puts these controls on a
	// bus owns the fixed offsets inside the map's span (MAP_SPAN)

	////////////////////////////////////////////////////////////////
	// Change classifier for the issuing channel, one flag per trigger.
	// Every flag compares the moved value with the channel's live copy,
	// so rewriting a register with what it already holds is free
	always_comb begin
		dLaneChg = 1'b0;
		sLaneChg = 1'b0;
		swapChg = 1'b0;
		dIncChg = 1'b0;
		dBeatChg = 1'b0;
		sIncChg = 1'b0;
		sBeatChg = 1'b0;
		case (moveTarget)
			MV_DST: begin
				// Low address bits pick the write lane of the wide bus
				dLaneChg = moveData[DST_AW-1:0] != s.ch[issueCh].dAlign;
			end
			MV_SRC: begin
				// Low address bits pick the read lane of the narrow bus
				sLaneChg = moveData[SRC_AW-1:0] != s.ch[issueCh].sAlign;
			end
			MV_CTL: begin
				swapChg = newCtl.swapSize != s.ch[issueCh].ctl.swapSize;
				dIncChg = newCtl.dstInc != s.ch[issueCh].ctl.dstInc;
				// Beat size only moves lanes while the destination address is fixed
				dBeatChg = !newCtl.dstInc && newCtl.dstBeat != s.ch[issueCh].ctl.dstBeat;
				sIncChg = newCtl.srcInc != s.ch[issueCh].ctl.srcInc;
				// Any source beat change re-packs the read lanes, fixed or not
				sBeatChg = newCtl.srcBeat != s.ch[issueCh].ctl.srcBeat;
			end
			default: begin
				dLaneChg = 1'b0;
			end
		endcase
		// The flags are only acted on for an accepted move of a running channel
		dHit = dLaneChg || swapChg || dIncChg || dBeatChg;
		sHit = sLaneChg || sIncChg || sBeatChg;
	end

	////////////////////////////////////////////////////////////////
	// Discontinuity detection and resync sequencing
	always_comb begin
		next_s = s;
		for (int i = 0; i < NCH; i++) begin
			next_s.ch[i].dstB = 1'b0;
			next_s.ch[i].srcB = 1'b0;
			case (s.ch[i].st)
				RS_RUN: begin
					if (issueAccept && isMove && issueCh == CH_W'(i)) begin
						// Keep the live copy current so a repeat of this move is free
						case (moveTarget)
							MV_DST: begin
								next_s.ch[i].dAlign = moveData[DST_AW-1:0];
							end
							MV_SRC: begin
								next_s.ch[i].sAlign = moveData[SRC_AW-1:0];
							end
							MV_CTL: begin
								next_s.ch[i].ctl = newCtl;
							end
							default: begin
								next_s.ch[i].ctl = s.ch[i].ctl;
							end
						endcase
						// Destination break dominates: its drain covers reads too
						if (dHit) begin
							next_s.ch[i].st = RS_DRAIN_ALL;
							next_s.ch[i].dstB = 1'b1;
						end else if (sHit) begin
							next_s.ch[i].st = RS_DRAIN_RD;
							next_s.ch[i].srcB = 1'b1;
						end
					end
				end
				RS_DRAIN_RD: begin
					// FIFO contents kept intact
					if (!rdPending[i]) begin
						next_s.ch[i].st = RS_RUN;
					end
				end
				RS_DRAIN_ALL: begin
					if (!rdPending[i] && !wrPending[i]) begin
						next_s.ch[i].st = RS_FLUSH;
					end
				end
				RS_FLUSH: begin
					if (flushDone[i]) begin
						next_s.ch[i].st = RS_RUN;
					end
				end
				default: begin
					next_s.ch[i].st = RS_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////
	// Status outputs per channel
	// Halt covers every resync phase, so the sequencer needs one stall bit only;
	// the break pulses last one cycle and tell which stream was cut.
	// The purge request stands until the FIFO side answers, so a slow purge
	// simply stretches the halt instead of letting stale data through.
	for (genvar g = 0; g < NCH; g++) begin : gOut
		assign chHalted[g] = s.ch[g].st != RS_RUN;
		assign fifoFlushReq[g] = s.ch[g].st == RS_FLUSH;
		assign dstBreak[g] = s.ch[g].dstB;
		assign srcBreak[g] = s.ch[g].srcB;
	end
endmodule

// ### tb/dsl_properties.sv
// Checker: port-level properties of the stream control block
`timescale 1ns/100ps
module dsl_properties #(parameter int NCH = 8) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic issue,
	input wire dsl_pkg::dsl_instr_t instr,
	input wire logic [dsl_pkg::CH_W-1:0] issueCh,
	input wire logic [NCH-1:0] rdPending,
	input wire logic [NCH-1:0] wrPending,
	input wire logic issueAccept,
	input wire logic [NCH-1:0] chHalted,
	input wire logic [NCH-1:0] fifoFlushReq,
	input wire logic [NCH-1:0] dstBreak,
	input wire logic [NCH-1:0] srcBreak,
	input wire logic lockHeld,
	input wire logic [dsl_pkg::CH_W-1:0] lockOwner
);
	import dsl_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Owner issue taken this cycle; only these may free the token
	wire own = issue && issueAccept && lockHeld && lockOwner == issueCh;
	////////////////////////////////////////////////////////////////
	a_lock_claim: assert property (issue && issueAccept && instr inside {INS_LOAD, INS_PLOAD} && !lockHeld
		|=> lockHeld && lockOwner == $past(issueCh)) else $error("load did not claim");
	a_load_stall: assert property (issue && instr inside {INS_LOAD, INS_PLOAD} && lockHeld
		&& lockOwner != issueCh |-> !issueAccept) else $error("foreign load accepted");
	a_store_free: assert property (own && instr inside {INS_STORE, INS_PSTORE, INS_ZSTORE} |=> !lockHeld)
		else $error("store kept lock");
	a_barrier_free: assert property (own && instr inside {INS_RBAR, INS_WBAR} |=> !lockHeld)
		else $error("barrier kept lock");
	a_wait_free: assert property (own && instr inside {INS_WFP, INS_WFE} |=> !lockHeld)
		else $error("wait kept lock");
	a_end_free: assert property (own && instr inside {INS_END, INS_KILL, INS_ABORT} |=> !lockHeld)
		else $error("end kept lock");
	a_owner_hold: assert property (lockHeld && !own |=> lockHeld && $stable(lockOwner))
		else $error("owner moved");
	a_halt_refuse: assert property (issue && chHalted[issueCh] && !(instr inside {INS_KILL, INS_ABORT})
		|-> !issueAccept) else $error("halted channel ran");
	a_flush_drained: assert property ((fifoFlushReq & ~$past(fifoFlushReq)
		& ($past(rdPending) | $past(wrPending))) == '0) else $error("purge before drain");
	a_break_halts: assert property ((dstBreak | srcBreak) != '0 |-> ((dstBreak | srcBreak) & ~chHalted) == '0)
		else $error("break without halt");
	c_dst: cover property (dstBreak != '0);
	c_src: cover property (srcBreak != '0);
	c_stall: cover property (lockHeld && issue && !issueAccept);
endmodule
bind dsl_stream_ctrl dsl_properties #(.NCH(NCH)) u_props (.clk(clk), .rst_n(rst_n), .issue(issue), .instr(instr),
	.issueCh(issueCh), .rdPending(rdPending), .wrPending(wrPending), .issueAccept(issueAccept), .chHalted(chHalted),
	.fifoFlushReq(fifoFlushReq), .dstBreak(dstBreak), .srcBreak(srcBreak), .lockHeld(lockHeld), .lockOwner(lockOwner));

// ### tb/dsl_far_side.sv
// Far-side model: bus traffic in flight and FIFO purge answers per channel
`timescale 1ns/100ps
module dsl_far_side #(parameter int NCH = 8, parameter int LAT = 8) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [NCH-1:0] chHalted,
	input wire logic [NCH-1:0] fifoFlushReq,
	output logic [NCH-1:0] rdPending,
	output logic [NCH-1:0] wrPending,
	output logic [NCH-1:0] flushDone
);
	logic [3:0] cnt [NCH];
	// Running channels always have traffic; a halt drains it, reads first, so writes outlive reads
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flushDone <= '0;
			for (int c = 0; c < NCH; c++) cnt[c] <= '0;
		end else begin
			flushDone <= fifoFlushReq & ~flushDone;
			for (int c = 0; c < NCH; c++) cnt[c] <= !chHalted[c] ? 4'(LAT) : cnt[c] - 4'(cnt[c] != 0);
		end
	end
	always_comb for (int c = 0; c < NCH; c++) begin
		rdPending[c] = cnt[c] > 4'(LAT / 2);
		wrPending[c] = cnt[c] != 0;
	end
endmodule

// ### tb/testbench.sv
// Testbench: load-lock and stream break scenarios
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; $display("Error %0t: %h vs %h", $time, a, b); end end
module testbench;
	import dsl_pkg::*;
	logic clk = 0;
	logic rst_n = 0;
	logic issue = 0;
	dsl_instr_t instr = INS_NONE;
	logic [2:0] issueCh = 0;
	logic [31:0] moveData = 0;
	dsl_mvtgt_t moveTarget = MV_SRC;
	logic isMove = 0;
	logic [7:0] rdPending, wrPending, flushDone, chHalted, fifoFlushReq, dstBreak, srcBreak;
	logic issueAccept, lockHeld, acc, sawFlush, wrLeft;
	logic [2:0] lockOwner;
	int n_errors = 0;
	int check_count = 0;
	always #2.5 clk = ~clk;
	dsl_stream_ctrl dut (
		.clk(clk),
		.rst_n(rst_n),
		.issue(issue),
		.instr(instr),
		.issueCh(issueCh),
		.moveData(moveData),
		.moveTarget(moveTarget),
		.isMove(isMove),
		.rdPending(rdPending),
		.wrPending(wrPending),
		.flushDone(flushDone),
		.issueAccept(issueAccept),
		.chHalted(chHalted),
		.fifoFlushReq(fifoFlushReq),
		.dstBreak(dstBreak),
		.srcBreak(srcBreak),
		.lockHeld(lockHeld),
		.lockOwner(lockOwner)
	);
	dsl_far_side fs (
		.clk(clk),
		.rst_n(rst_n),
		.chHalted(chHalted),
		.fifoFlushReq(fifoFlushReq),
		.rdPending(rdPending),
		.wrPending(wrPending),
		.flushDone(flushDone)
	);
	////////////////////////////////////////////////////////////////
	// One instruction; acceptance is sampled once the inputs settle
	// Stimulus never touches the register map and moves only defined fields
	task automatic op(input logic [2:0] c, input dsl_instr_t i, input logic m = 0, input dsl_mvtgt_t t = MV_SRC,
		input logic [31:0] d = 0);
		@(posedge clk) #1;
		issue = 1;
		issueCh = c;
		instr = i;
		isMove = m;
		moveTarget = t;
		moveData = d;
		#1 acc = issueAccept;
		@(posedge clk) #1;
		issue = 0;
		isMove = 0;
	endtask
	// Bounded wait for a resync to finish, noting purge and leftover writes
	task automatic settle(input int c);
		sawFlush = 0;
		repeat (40) if (chHalted[c]) begin
			@(posedge clk) #1;
			sawFlush |= fifoFlushReq[c];
			wrLeft = wrPending[c];
		end
		`CHK(chHalted[c], 1'b0)
	endtask
	task automatic t_lock();
		dsl_instr_t rel [10] = '{INS_STORE, INS_PSTORE, INS_ZSTORE, INS_RBAR, INS_WBAR, INS_WFP, INS_WFE, INS_END,
			INS_KILL, INS_ABORT};
		// One loader at a time, released before the next load: FIFO demand stays in depth
		foreach (rel[k]) begin
			op(2, (k % 2) ? INS_PLOAD : INS_LOAD);
			`CHK({acc, lockHeld, lockOwner}, 5'h1A)
			op(5, INS_LOAD);
			`CHK({acc, lockOwner}, 4'h2)
			op(2, rel[k]);
			`CHK(lockHeld, 1'b0)
		end
		$display("lock test done");
	endtask
	task automatic t_dst();
		op(1, INS_OTHER, 1, MV_DST, 32'h0000_0008);
		`CHK({dstBreak[1], chHalted[1]}, 2'h0)
		op(1, INS_OTHER, 1, MV_DST, 32'h0000_000C);
		`CHK({dstBreak[1], chHalted[1]}, 2'h3)
		op(1, INS_LOAD);
		`CHK(acc, 1'b0)
		settle(1);
		`CHK(sawFlush, 1'b1)
		$display("dest test done");
	endtask
	task automatic t_src();
		logic [31:0] d [3] = '{32'h0000_0080, 32'h0000_0091, 32'h0000_0191};
		logic [1:0] e [3] = '{2'h2, 2'h1, 2'h2};
		op(3, INS_OTHER, 1, MV_SRC, 32'h0000_0004);
		`CHK({srcBreak[3], chHalted[3]}, 2'h0)
		op(3, INS_OTHER, 1, MV_SRC, 32'h0000_0005);
		`CHK({srcBreak[3], chHalted[3]}, 2'h3)
		settle(3);
		`CHK({sawFlush, wrLeft}, 2'h1)
		// Control moves: dest increment, then dest beat with incrementing dest plus source beat, then swap size
		foreach (d[k]) begin
			op(4, INS_OTHER, 1, MV_CTL, d[k]);
			`CHK({dstBreak[4], srcBreak[4]}, e[k])
			settle(4);
		end
		$display("source test done");
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		#1 rst_n = 1;
		`CHK({lockHeld, lockOwner, chHalted, fifoFlushReq, dstBreak, srcBreak}, 36'h0)
		t_lock();
		t_dst();
		t_src();
		give_verdict();
	end
	// Watchdog well past the hundred-odd cycles the tests need
	initial begin
		#20000;
		n_errors++;
		give_verdict();
	end
endmodule
